/* hdl/mtc_pkg.sv */
// Package: constants, register map and state types of the transmit config block
package mtc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFF_TX_CFG    = 8'h24;
    localparam logic [7:0]  OFF_EV_STATUS = 8'h40;
    localparam logic [7:0]  OFF_EV_MASK   = 8'h44;
    localparam logic [7:0]  OFF_QE_COUNT  = 8'h48;
    localparam logic [7:0]  OFF_TX_STATUS = 8'h4C;
    localparam logic [31:0] CFG_RST       = 32'h0000_0102;
    localparam logic [31:0] CFG_WMASK     = 32'hFCF0_3F3F;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_CSI      = 31;
    localparam int CFG_HBI      = 30;
    localparam int CFG_LOOP     = 29;
    localparam int CFG_PAD      = 28;
    localparam int CFG_TRIM_HI  = 27;
    localparam int CFG_TRIM_LO  = 26;
    localparam int CFG_RETRY    = 23;
    localparam int EV_TX_OK     = 0;
    localparam int EV_ABORT     = 1;
    localparam int EV_CARRIER   = 2;
    localparam int EV_HEARTBEAT = 3;
    localparam int ST_EXT       = 15;
    localparam int ST_CARRIER   = 14;
    localparam int ST_HB_FAIL   = 13;
    localparam int ST_ABORT     = 12;
    localparam int ST_OK        = 11;

    // ------------------------------------------------------------------
    // Frame, collision and timing figures
    // ------------------------------------------------------------------
    localparam logic [10:0] MIN_FRAME_LEN    = 11'h040;
    localparam logic [6:0]  ATTEMPTS_STD     = 7'h10;
    localparam logic [6:0]  ATTEMPTS_EXT     = 7'h40;
    localparam int          CLK_PERIOD_NS    = 25;
    localparam int          IFG_10_NS        = 9600;
    localparam int          IFG_STEP_10_NS   = 400;
    localparam int          IFG_100_NS       = 960;
    localparam int          IFG_STEP_100_NS  = 40;
    localparam int          HB_WINDOW_NS     = 400;
    localparam logic [4:0]  HB_CYCLES        =
        5'(HB_WINDOW_NS / CLK_PERIOD_NS);

    // Gap in clock cycles, least time so rounded up
    function automatic logic [8:0] mtc_gap_cycles(input logic       fast,
                                                   input logic [1:0] trim);
        int ns;
        ns = fast ? IFG_100_NS - IFG_STEP_100_NS * int'(trim)
                  : IFG_10_NS - IFG_STEP_10_NS * int'(trim);
        return 9'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [8:0] cnt;
        logic       busy;
    } mtc_gap_t;

    typedef struct packed {
        logic [31:0] cfg;
        logic [3:0]  ev_status;
        logic [3:0]  ev_mask;
        logic [15:0] qe_count;
        logic [15:0] tx_status;
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        in_frame;
        logic [6:0]  attempts;
        logic        carrier_lost;
        logic        hb_wait;
        logic [4:0]  hb_cnt;
        logic        tx_abort;
        logic        tx_ok;
        logic        tx_ready;
        logic [10:0] send_len;
        logic        mii_tx_en;
        logic [3:0]  mii_txd;
        logic        mii_rx_enable;
        logic        lb_rx_dv;
        logic [3:0]  lb_rxd;
        logic        rx_loopback_flag;
        logic        irq;
    } mtc_state_t;

endpackage

/* hdl/mtc_gap_timer.sv */
// Interframe gap timer, length set by line rate and gap trim
`timescale 1ns/1ps
`default_nettype none
module mtc_gap_timer
    import mtc_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       start,
    input  wire logic       fast,
    input  wire logic [1:0] trim,
    output logic            busy
);

    mtc_gap_t r;
    mtc_gap_t n;

    // ------------------------------------------------------------------
    // Countdown
    // ------------------------------------------------------------------
    // Busy for exactly the gap length in cycles
    always_comb
    begin
        n = r;
        if (start)
        begin
            n.cnt  = mtc_gap_cycles(fast, trim);  // R11 R12
            n.busy = 1'b1;
        end
        else if (r.cnt > 9'h001)
        begin
            n.cnt = r.cnt - 9'h001;
        end
        else
        begin
            n.cnt  = 9'h000;
            n.busy = 1'b0;
        end
    end

    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '0;
        else
            r <= n;
    end

    // Falls one cycle early, as the parent registers its ready
    assign busy = r.busy && (r.cnt > 9'h001);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_gap_len;
        logic [8:0] c;
        (start, c = mtc_gap_cycles(fast, trim)) |=> (r.cnt == c) && r.busy;
    endproperty
    a_gap_len: assert property (p_gap_len)  // R11
        else $error("gap length does not match trim and rate");

    property p_gap_fast_min;
        start && fast |=> r.cnt >= 9'd34 && r.cnt <= 9'd39;
    endproperty
    a_gap_fast_min: assert property (p_gap_fast_min)  // R12
        else $error("fast gap outside 840 to 960 ns");

endmodule
`default_nettype wire

/* hdl/mtc_tx_config.sv */
// Transmit configuration block: AXI4-Lite registers and transmit control
// Function
// [R1] Carrier-sense ignore set: carrier activity ignored, no carrier status.
// [R2] Carrier-sense ignore clear: carrier watched per frame and reported.
// [R3] Software sets both ignore bits before full-duplex use.
// [R4] Heartbeat ignore set: no heartbeat check, no quality-error counting.
// [R5] Heartbeat ignore clear: missing heartbeat increments quality-error count.
// [R6] Loopback: transmit fed to receiver, both MII directions disabled.
// [R7] Software disables transmitter and receiver before setting loopback.
// [R8] Frames received in loopback carry the loopback flag.
// [R9] Auto padding extends short frames to 64 bytes.
// [R10] Padding off: short frames sent unpadded.
// [R11] At 10 Mb/s gap is 9.6 us minus 0.4 us per trim step.
// [R12] At 100 Mb/s gap is 960 ns minus 40 ns per trim step.
// [R13] Bits 25-24 ignore writes and read zero.
// [R14] Retry on: up to four rounds, abort after 64th attempt.
// [R15] Retry off: abort after the 16th attempt.
// [R16] Retry on: collision status uses the extended round reporting.
// [R17] Reset clears control bits 31 to 23.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module mtc_tx_config
    import mtc_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              tx_frame_start,
    input  wire logic [10:0]       tx_frame_len,
    input  wire logic              tx_done,
    input  wire logic              tx_collision,
    input  wire logic              link_100,
    input  wire logic              mii_crs,
    input  wire logic              mii_col,
    input  wire logic              tx_en_in,
    input  wire logic [3:0]        txd_in,
    output logic                   tx_ready,
    output logic [10:0]            send_len,
    output logic                   tx_abort,
    output logic                   tx_ok,
    output logic [15:0]            tx_status,
    output logic                   mii_tx_en,
    output logic [3:0]             mii_txd,
    output logic                   mii_rx_enable,
    output logic                   lb_rx_dv,
    output logic [3:0]             lb_rxd,
    output logic                   rx_loopback_flag,
    output logic                   irq
);

    // Byte strobes to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // Word address match
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    mtc_state_t  r;
    mtc_state_t  n;
    logic        gap_busy;
    logic        gap_start;
    logic [3:0]  ev_set;
    logic [3:0]  w1c;
    logic [31:0] wm;
    logic [6:0]  next_att;
    logic [6:0]  limit;

    // ------------------------------------------------------------------
    // Interframe gap
    // ------------------------------------------------------------------
    mtc_gap_timer u_gap (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (gap_start),
        .fast    (link_100),
        .trim    (r.cfg[CFG_TRIM_HI:CFG_TRIM_LO]),
        .busy    (gap_busy)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        n         = r;
        gap_start = 1'b0;
        ev_set    = 4'h0;
        w1c       = 4'h0;
        wm        = strb_mask(r.w_strb) & CFG_WMASK;
        next_att  = r.attempts + 7'h01;
        limit     = r.cfg[CFG_RETRY] ? ATTEMPTS_EXT : ATTEMPTS_STD;
        n.tx_abort = 1'b0;
        n.tx_ok    = 1'b0;

        // Write address and data taken in either order
        if (s_axi_awvalid && r.awready)
        begin
            n.aw_full = 1'b1;
            n.aw_addr = s_axi_awaddr;
            n.awready = 1'b0;
        end
        if (s_axi_wvalid && r.wready)
        begin
            n.w_full  = 1'b1;
            n.w_data  = s_axi_wdata;
            n.w_strb  = s_axi_wstrb;
            n.wready  = 1'b0;
        end
        if (r.bvalid && s_axi_bready)
            n.bvalid = 1'b0;

        // Register write once both halves are held
        if (r.aw_full && r.w_full && !r.bvalid)
        begin
            n.aw_full = 1'b0;
            n.w_full  = 1'b0;
            n.awready = 1'b1;
            n.wready  = 1'b1;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OKAY;
            if (hit(r.aw_addr, OFF_TX_CFG))
                n.cfg = (r.cfg & ~wm) | (r.w_data & wm);  // R13
            else if (hit(r.aw_addr, OFF_EV_MASK))
                n.ev_mask = (r.ev_mask & ~{4{r.w_strb[0]}})
                          | (r.w_data[3:0] & {4{r.w_strb[0]}});
            else if (hit(r.aw_addr, OFF_EV_STATUS))
                w1c = r.w_data[3:0] & {4{r.w_strb[0]}};
            else if (!hit(r.aw_addr, OFF_QE_COUNT)
                     && !hit(r.aw_addr, OFF_TX_STATUS))
                n.bresp = RESP_SLVERR;
        end

        // Register read
        if (s_axi_arvalid && r.arready)
        begin
            n.arready = 1'b0;
            n.rvalid  = 1'b1;
            n.rresp   = RESP_OKAY;
            n.rdata   = 32'h0000_0000;
            if (hit(s_axi_araddr, OFF_TX_CFG))
                n.rdata = r.cfg;
            else if (hit(s_axi_araddr, OFF_EV_STATUS))
                n.rdata[3:0] = r.ev_status;
            else if (hit(s_axi_araddr, OFF_EV_MASK))
                n.rdata[3:0] = r.ev_mask;
            else if (hit(s_axi_araddr, OFF_QE_COUNT))
                n.rdata[15:0] = r.qe_count;
            else if (hit(s_axi_araddr, OFF_TX_STATUS))
                n.rdata[15:0] = r.tx_status;
            else
                n.rresp = RESP_SLVERR;
        end
        else if (r.rvalid && s_axi_rready)
        begin
            n.rvalid  = 1'b0;
            n.arready = 1'b1;
        end

        // Frame start and padding
        if (tx_frame_start && !r.in_frame)
        begin
            n.in_frame     = 1'b1;
            n.attempts     = 7'h00;
            n.carrier_lost = 1'b0;
            if (r.cfg[CFG_PAD] && tx_frame_len < MIN_FRAME_LEN)
                n.send_len = MIN_FRAME_LEN;  // R9
            else
                n.send_len = tx_frame_len;  // R10
        end
        else if (r.in_frame)
        begin
            // Carrier watched only when not ignored
            if (!r.cfg[CFG_CSI] && !mii_crs && !r.carrier_lost)  // R1 R2
            begin
                n.carrier_lost     = 1'b1;
                ev_set[EV_CARRIER] = 1'b1;
            end
            if (tx_collision)
            begin
                n.attempts = next_att;
                if (next_att == limit)  // R14 R15
                begin
                    n.in_frame       = 1'b0;
                    n.tx_abort       = 1'b1;
                    ev_set[EV_ABORT] = 1'b1;
                    gap_start        = 1'b1;
                end
            end
            else if (tx_done)
            begin
                n.in_frame       = 1'b0;
                n.tx_ok          = 1'b1;
                ev_set[EV_TX_OK] = 1'b1;
                gap_start        = 1'b1;
                n.hb_wait        = !r.cfg[CFG_HBI];  // R4
                n.hb_cnt         = HB_CYCLES;
            end
            // Status snapshot at frame end
            if (gap_start)
            begin
                n.tx_status              = 16'h0000;
                n.tx_status[ST_EXT]      = r.cfg[CFG_RETRY];
                n.tx_status[ST_CARRIER]  = n.carrier_lost;
                n.tx_status[ST_ABORT]    = n.tx_abort;
                n.tx_status[ST_OK]       = n.tx_ok;
                n.tx_status[5:0]         = r.cfg[CFG_RETRY]  // R16
                    ? n.attempts[5:0] : {2'h0, n.attempts[3:0]};
            end
        end

        // Heartbeat window after a good frame
        if (r.hb_wait)
        begin
            if (r.cfg[CFG_HBI] || mii_col)
                n.hb_wait = 1'b0;
            else if (r.hb_cnt == 5'h01)
            begin
                n.hb_wait              = 1'b0;
                n.qe_count             = r.qe_count + 16'h0001;  // R5
                n.tx_status[ST_HB_FAIL] = 1'b1;
                ev_set[EV_HEARTBEAT]   = 1'b1;
            end
            else
                n.hb_cnt = r.hb_cnt - 5'h01;
        end

        // Loopback routing, MII disabled while looping
        n.mii_tx_en        = tx_en_in && !r.cfg[CFG_LOOP];  // R6
        n.mii_txd          = r.cfg[CFG_LOOP] ? 4'h0 : txd_in;
        n.mii_rx_enable    = !r.cfg[CFG_LOOP];
        n.lb_rx_dv         = tx_en_in && r.cfg[CFG_LOOP];
        n.lb_rxd           = r.cfg[CFG_LOOP] ? txd_in : 4'h0;
        n.rx_loopback_flag = r.cfg[CFG_LOOP];  // R8

        // Sticky events, set wins over clear
        n.ev_status = (r.ev_status & ~w1c) | ev_set;
        n.irq       = |(n.ev_status & n.ev_mask);
        n.tx_ready  = !n.in_frame && !gap_busy && !gap_start;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r         <= '0;
            r.cfg     <= CFG_RST;  // R17
            r.awready <= 1'b1;
            r.wready  <= 1'b1;
            r.arready <= 1'b1;
        end
        else
            r <= n;
    end

    // Outputs straight from the state register
    assign s_axi_awready    = r.awready;
    assign s_axi_wready     = r.wready;
    assign s_axi_bresp      = r.bresp;
    assign s_axi_bvalid     = r.bvalid;
    assign s_axi_arready    = r.arready;
    assign s_axi_rdata      = r.rdata;
    assign s_axi_rresp      = r.rresp;
    assign s_axi_rvalid     = r.rvalid;
    assign tx_ready         = r.tx_ready;
    assign send_len         = r.send_len;
    assign tx_abort         = r.tx_abort;
    assign tx_ok            = r.tx_ok;
    assign tx_status        = r.tx_status;
    assign mii_tx_en        = r.mii_tx_en;
    assign mii_txd          = r.mii_txd;
    assign mii_rx_enable    = r.mii_rx_enable;
    assign lb_rx_dv         = r.lb_rx_dv;
    assign lb_rxd           = r.lb_rxd;
    assign rx_loopback_flag = r.rx_loopback_flag;
    assign irq              = r.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_csi_quiet;
        $rose(r.carrier_lost) |-> !$past(r.cfg[CFG_CSI]);
    endproperty
    a_csi_quiet: assert property (p_csi_quiet)  // R1
        else $error("carrier loss flagged while ignored");

    property p_crs_watch;
        r.in_frame && !r.cfg[CFG_CSI] && !mii_crs && !tx_collision
            && !tx_done |=> r.carrier_lost;
    endproperty
    a_crs_watch: assert property (p_crs_watch)  // R2
        else $error("carrier drop not flagged");

    property p_hbi_no_count;
        r.cfg[CFG_HBI] |=> $stable(r.qe_count);
    endproperty
    a_hbi_no_count: assert property (p_hbi_no_count)  // R4
        else $error("quality error counted while ignored");

    sequence s_hb_missed;
        r.hb_wait && r.hb_cnt == 5'h01 && !mii_col && !r.cfg[CFG_HBI];
    endsequence
    property p_hb_count;
        s_hb_missed |=> r.qe_count == $past(r.qe_count) + 16'h0001;
    endproperty
    a_hb_count: assert property (p_hb_count)  // R5
        else $error("missed heartbeat not counted");

    property p_loop_mii_off;
        r.cfg[CFG_LOOP] |=> !mii_tx_en && !mii_rx_enable
            && lb_rx_dv == $past(tx_en_in);
    endproperty
    a_loop_mii_off: assert property (p_loop_mii_off)  // R6
        else $error("MII active during loopback");

    property p_loop_flag;
        r.cfg[CFG_LOOP] |=> rx_loopback_flag;
    endproperty
    a_loop_flag: assert property (p_loop_flag)  // R8
        else $error("loopback flag missing");

    property p_pad;
        tx_frame_start && !r.in_frame && r.cfg[CFG_PAD]
            && tx_frame_len < MIN_FRAME_LEN |=> send_len == 11'h040;
    endproperty
    a_pad: assert property (p_pad)  // R9
        else $error("short frame not padded to 64");

    property p_no_pad;
        tx_frame_start && !r.in_frame && !r.cfg[CFG_PAD]
            |=> send_len == $past(tx_frame_len);
    endproperty
    a_no_pad: assert property (p_no_pad)  // R10
        else $error("frame length altered without padding");

    property p_rsvd_zero;
        s_axi_rvalid |-> r.cfg[25:24] == 2'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)  // R13
        else $error("reserved bits not zero");

    sequence s_last_ext;
        r.in_frame && tx_collision && r.cfg[CFG_RETRY]
            && r.attempts == 7'd63;
    endsequence
    property p_abort_ext;
        s_last_ext |=> tx_abort ##1 !tx_abort;
    endproperty
    a_abort_ext: assert property (p_abort_ext)  // R14
        else $error("no abort after 64th attempt");

    property p_abort_std;
        tx_abort |-> $past(r.cfg[CFG_RETRY]) ? r.attempts == 7'd64
                                             : r.attempts == 7'd16;
    endproperty
    a_abort_std: assert property (p_abort_std)  // R15
        else $error("abort at wrong attempt count");

    property p_ext_status;
        $past(gap_start) && $past(r.cfg[CFG_RETRY])
            |-> tx_status[ST_EXT] && tx_status[5:4] == r.attempts[5:4];
    endproperty
    a_ext_status: assert property (p_ext_status)  // R16
        else $error("extended collision report missing");

    property p_reset_cfg;
        $past(!aresetn) |-> r.cfg[31:23] == 9'h000;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg)  // R17
        else $error("control bits not cleared by reset");

endmodule
`default_nettype wire

/* bench/mtc_phy_model.sv */
// Behavioural PHY model: carrier level and heartbeat pulse
`timescale 1ns/1ps
`default_nettype none
module mtc_phy_model (
    input  wire logic aclk,
    input  wire logic tx_en,
    input  wire logic carrier_on,
    input  wire logic hb_on,
    output logic      crs,
    output logic      col
);
    logic [3:0] hb_sh = 4'h0;
    logic       en_d  = 1'b0;

    // Heartbeat pulse shortly after transmit ends
    always_ff @(posedge aclk)
    begin
        en_d  <= tx_en;
        hb_sh <= {hb_sh[2:0], en_d & ~tx_en & hb_on};
    end

    // Carrier level and collision-detect line
    assign crs = carrier_on;
    assign col = hb_sh[2] | hb_sh[3];
endmodule
`default_nettype wire

/* bench/tb_mac_transmit_config.sv */
// Testbench of the transmit configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_mac_transmit_config
    import mtc_pkg::*;
;
    typedef struct packed {
        logic [8:0]  hi;
        logic        fast;
        logic [10:0] len;
        logic [6:0]  ncol;
        logic        crs;
        logic        hb;
        logic [4:0]  est;
        logic [8:0]  gap;
    } mtc_row_t;
    logic        aclk, aresetn = 1'b0, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0]  s_axi_wstrb, txd_in, mii_txd, lb_rxd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
    logic        tx_frame_start, tx_done, tx_collision, link_100, mii_crs;
    logic        mii_col, tx_en_in, tx_ready, tx_abort, tx_ok, mii_tx_en;
    logic        mii_rx_enable, lb_rx_dv, rx_loopback_flag, irq, crs_on;
    logic        hb_on;
    logic [10:0] tx_frame_len, send_len;
    logic [15:0] tx_status;
    int          checks, bad_count, n, qe;
    mtc_row_t    rows [6];

    mtc_tx_config u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .tx_frame_start, .tx_frame_len,
        .tx_done, .tx_collision, .link_100, .mii_crs, .mii_col, .tx_en_in,
        .txd_in, .tx_ready, .send_len, .tx_abort, .tx_ok, .tx_status,
        .mii_tx_en, .mii_txd, .mii_rx_enable, .lb_rx_dv, .lb_rxd,
        .rx_loopback_flag, .irq
    );
    mtc_phy_model u_phy (.aclk, .tx_en(mii_tx_en), .carrier_on(crs_on),
        .hb_on, .crs(mii_crs), .col(mii_col));

    // Clock, 25 ns period
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rd_r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // One frame: start, collisions, end, then gap and status
    task automatic run(input mtc_row_t r);
        wr(OFF_TX_CFG, {r.hi, 23'h000102});
        link_100 <= r.fast;
        crs_on   <= r.crs;
        hb_on    <= r.hb;
        @(posedge aclk);
        tx_frame_start <= 1'b1;
        tx_frame_len   <= r.len;
        tx_en_in       <= 1'b1;
        @(posedge aclk);
        tx_frame_start <= 1'b0;
        #1;
        chk(send_len, (r.hi[5] && r.len < 64) ? 11'h040 : r.len);
        chk({mii_tx_en, mii_txd, lb_rx_dv, lb_rxd, mii_rx_enable,
             rx_loopback_flag}, r.hi[6] ? 12'h069 : 12'hD02);
        repeat (r.ncol)
        begin
            @(posedge aclk);
            tx_collision <= 1'b1;
        end
        @(posedge aclk);
        tx_collision <= 1'b0;
        tx_en_in     <= 1'b0;
        if (!r.est[1])
        begin
            tx_done <= 1'b1;
            @(posedge aclk);
            tx_done <= 1'b0;
        end
        #1;
        chk({tx_ok, tx_abort}, {!r.est[1], r.est[1]});
        n = 0;
        while (!tx_ready && n < 1000)
        begin
            n++;
            @(posedge aclk);
            #1;
        end
        chk(n, r.gap);
        chk(tx_status[15:11], r.est);
        qe += r.est[2];
        rd(OFF_QE_COUNT);
        chk(rd_d, qe);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, tx_frame_start, tx_frame_len, tx_done} = '0;
        {tx_collision, link_100, crs_on, hb_on, tx_en_in} = '0;
        s_axi_wstrb = 4'hF;
        txd_in      = 4'hA;
        checks      = 0;
        bad_count   = 0;
        qe          = 0;
        rows[0] = '{9'h020, 1'b1, 11'h028, 7'h00, 1'b1, 1'b1, 5'h01, 9'h027};
        rows[1] = '{9'h018, 1'b1, 11'h028, 7'h03, 1'b0, 1'b0, 5'h0D, 9'h022};
        rows[2] = '{9'h180, 1'b0, 11'h064, 7'h00, 1'b0, 1'b0, 5'h01, 9'h180};
        rows[3] = '{9'h000, 1'b1, 11'h050, 7'h10, 1'b1, 1'b1, 5'h02, 9'h027};
        rows[4] = '{9'h001, 1'b1, 11'h050, 7'h40, 1'b1, 1'b1, 5'h12, 9'h027};
        rows[5] = '{9'h0C0, 1'b1, 11'h050, 7'h00, 1'b1, 1'b0, 5'h01, 9'h027};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_TX_CFG);
        chk(rd_d, CFG_RST);
        wr(OFF_TX_CFG, 32'hFFFF_FFFF);
        chk(rd_r, RESP_OKAY);
        rd(OFF_TX_CFG);
        chk(rd_d, CFG_WMASK);
        rd(8'h10);
        chk(rd_r, RESP_SLVERR);
        $display("register test done");
        for (int i = 0; i < 6; i++)
        begin
            run(rows[i]);
            $display("row %0d done", i);
        end
        chk(irq, 1'b0);
        wr(OFF_EV_MASK, 32'h0000_0001);
        @(posedge aclk);
        #1;
        chk(irq, 1'b1);
        wr(OFF_EV_STATUS, 32'h0000_000F);
        @(posedge aclk);
        #1;
        chk(irq, 1'b0);
        $display("interrupt test done");
        stop_test;
    end

    // Watchdog against a hang
    initial
    begin
        #500000;
        bad_count++;
        stop_test;
    end
endmodule
`default_nettype wire
